/* File: hw/lrp_port.sv */
/*
 device end: splits the concatenated request buses into independent lane slaves,
 each with its own register array and busy bit.
 assumes the master holds requests stable while busy is high.
*/
`default_nettype none
module lrp_port #(parameter int LANES = lrp_pkg::LANES_R4) (
   lrp_if.dev bus
);

   localparam int AW = lrp_pkg::ADDR_W;
   localparam int DW = lrp_pkg::DATA_W;

   // the one wait cycle in which the array is read or written
   function automatic logic is_last_wait(
      input lrp_pkg::lrp_state_t lane_state,
      input logic [1:0]          cnt
   );
      return (lane_state == lrp_pkg::LRP_WAIT) && (cnt == lrp_pkg::WAIT_LAST);
   endfunction

   // an idle lane takes the next strobe it sees
   function automatic logic lane_idle(
      input lrp_pkg::lrp_state_t lane_state
   );
      return lane_state == lrp_pkg::LRP_IDLE;
   endfunction

   // a lane is asked for work when either strobe is high
   function automatic logic has_req(
      input logic wr,
      input logic rd
   );
      return wr | rd;
   endfunction

   // lane n of a concatenated address bus, counted from the lsb
   function automatic logic [AW-1:0] addr_slice(
      input logic [LANES*AW-1:0] addr_bus,
      input int                  lane
   );
      return addr_bus[lane*AW +: AW];
   endfunction

   // lane n of a concatenated data bus, counted from the lsb
   function automatic logic [DW-1:0] data_slice(
      input logic [LANES*DW-1:0] data_bus,
      input int                  lane
   );
      return data_bus[lane*DW +: DW];
   endfunction

   // only the two- and four-slice builds exist
   if (LANES != lrp_pkg::LANES_R2 && LANES != lrp_pkg::LANES_R4) begin : g_bad_lanes
      $error("lane count must be two or four");
   end

   // an 11-bit offset must never index past the end of a lane's array
   if (lrp_pkg::REG_DEPTH < (1 << AW)) begin : g_bad_depth
      $error("register array shorter than the address space");
   end

   // counting starts at one, so a zero end count would only be reached after the 2-bit counter wraps
   if (lrp_pkg::WAIT_LAST == 2'h0) begin : g_bad_wait
      $error("wait count must be at least one");
   end

   // per-lane views of the concatenated buses
   logic [LANES-1:0] lane_wr;
   logic [LANES-1:0] lane_rd;
   logic [AW-1:0]    lane_addr  [LANES];
   logic [DW-1:0]    lane_wdata [LANES];
   logic [DW-1:0]    lane_rdata [LANES];
   logic [LANES-1:0] lane_busy;

   genvar n;

   // strobes: bit n asks lane n
   generate
      for (n = 0; n < LANES; n++) begin : g_strobe
         assign lane_wr[n] = bus.write[n];
         assign lane_rd[n] = bus.read[n];
      end
   endgenerate

   // addresses: 11-bit slice n belongs to lane n
   generate
      for (n = 0; n < LANES; n++) begin : g_addr
         assign lane_addr[n] = addr_slice(bus.address, n);
      end
   endgenerate

   // write data: 32-bit slice n pairs with address slice n
   generate
      for (n = 0; n < LANES; n++) begin : g_wdata
         assign lane_wdata[n] = data_slice(bus.writedata, n);
      end
   endgenerate

   // one independent slave per slice; lanes share only the clock and reset
   generate
      for (n = 0; n < LANES; n++) begin : g_lane
         lrp_pkg::lrp_state_t state_q;
         logic [1:0]          cnt_q;

         logic [DW-1:0]       mem [lrp_pkg::REG_DEPTH];
         logic [DW-1:0]       rdat_q;
         logic                req;
         logic                start;
         logic                touch;
         logic                wr_en;
         logic                rd_en;

         assign req   = has_req(lane_wr[n], lane_rd[n]);
         assign start = lane_idle(state_q) & req;
         assign touch = is_last_wait(state_q, cnt_q);

         // both strobes act if wrongly raised together: the array takes the write, read data gets the old word
         assign wr_en = touch & lane_wr[n];
         assign rd_en = touch & lane_rd[n];

         // fixed access latency stands in for the lane's internal arbitration
         always_ff @(posedge bus.i_mclk or posedge bus.i_sys_rst) begin
            if (bus.i_sys_rst) begin
               state_q <= lrp_pkg::LRP_IDLE;
            end else begin
               unique case (state_q)
                  lrp_pkg::LRP_IDLE: begin
                     if (start) begin
                        state_q <= lrp_pkg::LRP_WAIT;
                     end
                  end
                  lrp_pkg::LRP_WAIT: begin
                     if (touch) begin
                        state_q <= lrp_pkg::LRP_DONE;
                     end
                  end
                  lrp_pkg::LRP_DONE: begin
                     state_q <= lrp_pkg::LRP_IDLE;
                  end
                  default: begin
                     state_q <= lrp_pkg::LRP_IDLE;
                  end
               endcase
            end
         end

         // wait counter runs only while the lane is busy on a request
         always_ff @(posedge bus.i_mclk or posedge bus.i_sys_rst) begin
            if (bus.i_sys_rst) begin
               cnt_q <= 2'h0;
            end else if (state_q == lrp_pkg::LRP_WAIT) begin
               cnt_q <= cnt_q + 2'h1;
            end else if (start) begin
               cnt_q <= 2'h1;
            end
         end

         // the array is not reset: contents are undefined until written
         always_ff @(posedge bus.i_mclk) begin
            if (wr_en) begin
               mem[lane_addr[n]] <= lane_wdata[n];
            end
         end

         // read data only moves on a completing read, so it holds in between
         always_ff @(posedge bus.i_mclk or posedge bus.i_sys_rst) begin
            if (bus.i_sys_rst) begin
               rdat_q <= '0;
            end else if (rd_en) begin
               rdat_q <= mem[lane_addr[n]];
            end
         end

         // busy drops for exactly the completing cycle
         // busy also stands while idle, so a fresh strobe is never answered early
         assign lane_rdata[n] = rdat_q;
         assign lane_busy[n]  = ~(state_q == lrp_pkg::LRP_DONE);
      end
   endgenerate

   // read data: lane n answers on 32-bit slice n
   generate
      for (n = 0; n < LANES; n++) begin : g_rdata
         assign bus.readdata[n*DW +: DW] = lane_rdata[n];
      end
   endgenerate

   // busy: one independent bit per lane
   generate
      for (n = 0; n < LANES; n++) begin : g_busy
         assign bus.waitrequest[n] = lane_busy[n];
      end
   endgenerate
endmodule
`default_nettype wire

/* File: hw/lrp_pkg.sv */
/*
 package for the multi-lane reconfiguration port: lane counts, slice widths, timing.
 assumes a single reconfiguration clock shared by both ends.
*/
`default_nettype none
package lrp_pkg;
   localparam int LANES_R2        = 2;
   localparam int LANES_R4        = 4;
   localparam int ADDR_W          = 11;
   localparam int DATA_W          = 32;
   localparam int REG_DEPTH       = 2048;
   localparam int WAIT_CYCLES     = 2;
   localparam logic [1:0] WAIT_LAST = 2'h2;
   typedef enum logic [1:0] {
      LRP_IDLE = 2'b00,
      LRP_WAIT = 2'b01,
      LRP_DONE = 2'b10
   } lrp_state_t;
endpackage
`default_nettype wire

/* File: hw/lrp_if.sv */
/*
 interface joining the user-side master and the per-lane register slave.
 assumes one clock and one active-high reset supplied by the bench.
*/
`default_nettype none
interface lrp_if #(parameter int LANES = lrp_pkg::LANES_R4) (
   input wire logic i_mclk,
   input wire logic i_sys_rst
);
   logic [LANES-1:0]                 write;
   logic [LANES-1:0]                 read;
   logic [LANES*lrp_pkg::ADDR_W-1:0] address;
   logic [LANES*lrp_pkg::DATA_W-1:0] writedata;
   logic [LANES*lrp_pkg::DATA_W-1:0] readdata;
   logic [LANES-1:0]                 waitrequest;
   modport dev (input i_mclk, input i_sys_rst, input write, input read, input address,
                input writedata, output readdata, output waitrequest);
   modport mst (input i_mclk, input i_sys_rst, output write, output read, output address,
                output writedata, input readdata, input waitrequest);
endinterface
`default_nettype wire

/* File: hw/lrp_master.sv */
/*
 user-logic master: one command port per lane, drives the split request buses.
 assumes the device keeps busy high until each transfer completes.
*/
`default_nettype none
module lrp_master #(parameter int LANES = lrp_pkg::LANES_R4) (
   lrp_if.mst                              bus,
   input  wire logic [LANES-1:0]                 i_cmd_valid,
   input  wire logic [LANES-1:0]                 i_cmd_write,
   input  wire logic [LANES*lrp_pkg::ADDR_W-1:0] i_cmd_addr,
   input  wire logic [LANES*lrp_pkg::DATA_W-1:0] i_cmd_wdata,
   output logic      [LANES-1:0]                 o_cmd_ready,
   output logic      [LANES-1:0]                 o_rsp_valid,
   output logic      [LANES*lrp_pkg::DATA_W-1:0] o_rsp_rdata
);
   localparam int AW = lrp_pkg::ADDR_W;
   localparam int DW = lrp_pkg::DATA_W;
   genvar n;
   generate
      for (n = 0; n < LANES; n++) begin : g_lane
         logic          wr_q, rd_q, rsp_q;
         logic [AW-1:0] addr_q;
         logic [DW-1:0] wdat_q, rdat_q;
         logic          busy;
         assign busy = wr_q | rd_q;
         assign o_cmd_ready[n] = ~busy;
         // strobe, address and data held until busy falls
         always_ff @(posedge bus.i_mclk or posedge bus.i_sys_rst) begin
            if (bus.i_sys_rst) begin
               wr_q   <= 1'b0;
               rd_q   <= 1'b0;
               addr_q <= '0;
               wdat_q <= '0;
            end else if (busy) begin
               if (!bus.waitrequest[n]) begin
                  wr_q <= 1'b0;
                  rd_q <= 1'b0;
               end
            end else if (i_cmd_valid[n]) begin
               wr_q   <= i_cmd_write[n];
               rd_q   <= ~i_cmd_write[n];
               addr_q <= i_cmd_addr[n*AW +: AW];
               wdat_q <= i_cmd_wdata[n*DW +: DW];
            end
         end
         // capture read data only after busy drops
         always_ff @(posedge bus.i_mclk or posedge bus.i_sys_rst) begin
            if (bus.i_sys_rst) begin
               rsp_q  <= 1'b0;
               rdat_q <= '0;
            end else begin
               rsp_q <= rd_q & ~bus.waitrequest[n];
               if (rd_q && !bus.waitrequest[n]) begin
                  rdat_q <= bus.readdata[n*DW +: DW];
               end
            end
         end
         assign bus.write[n]              = wr_q;
         assign bus.read[n]               = rd_q;
         assign bus.address[n*AW +: AW]   = addr_q;
         assign bus.writedata[n*DW +: DW] = wdat_q;
         assign o_rsp_valid[n]            = rsp_q;
         assign o_rsp_rdata[n*DW +: DW]   = rdat_q;
      end
   endgenerate
endmodule
`default_nettype wire

/* File: testbench/lrp_checker.sv */
/* checker for the lane port wires.
 assumes it sits beside lrp_if with the same lane count. */
`default_nettype none
module lrp_checker #(parameter int LANES = 4) (
   input wire logic                 i_mclk,
   input wire logic                 i_sys_rst,
   input wire logic [LANES-1:0]     write,
   input wire logic [LANES-1:0]     read,
   input wire logic [LANES*32-1:0]  readdata,
   input wire logic [LANES-1:0]     waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   sequence req0; $rose(read[0] | write[0]); endsequence
   sequence busy2; waitrequest[0] [*2]; endsequence
   hold_busy_a:
      assert property (req0 |-> busy2) else $error("lane 0 done early");
   answer_in_a:
      assert property (req0 |-> ##[1:4] !waitrequest[0]) else $error("lane 0 no answer");
   lane1_answer_a:
      assert property ($rose(read[1] | write[1]) |-> ##[1:4] !waitrequest[1]) else $error("lane 1 no answer");
   done_once_a:
      assert property ((waitrequest | $past(waitrequest)) == '1) else $error("done too long");
   done_needs_req_a:
      assert property ((read | write | waitrequest) == '1) else $error("done without request");
   rdata_hold_a:
      assert property ($changed(readdata[31:0]) |-> !waitrequest[0]) else $error("lane 0 data moved");
   top_rdata_hold_a:
      assert property ($changed(readdata[LANES*32-1 -: 32]) |-> !waitrequest[LANES-1]) else $error("top lane data moved");
   reset_state_a:
      assert property (@(posedge i_mclk) disable iff (1'b0) i_sys_rst |-> waitrequest == '1 && readdata == '0)
         else $error("bad reset state");
endmodule
`default_nettype wire

/* File: testbench/lrp_tb.sv */
/* bench: master and port joined, all lanes written then read back.
 assumes the pair is self contained; no partner model. */
`default_nettype none
module lrp_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int L = lrp_pkg::LANES_R4;
   logic                   i_mclk = 1'b0;
   logic                   i_sys_rst = 1'b0;
   logic [L-1:0]           cmd_v = '0, cmd_w = '0, rdy, rsp_v;
   logic [L*11-1:0]        cmd_a = '0;
   logic [L*32-1:0]        cmd_d = '0, rsp_d;
   logic [31:0]            mem [L][16];
   int                     seed = 89, bad_count = 0, check_count = 0;
   always #10 i_mclk = ~i_mclk;
   lrp_if #(.LANES(L)) bus (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst));
   lrp_master #(.LANES(L)) i_lrp_master (.bus(bus), .i_cmd_valid(cmd_v), .i_cmd_write(cmd_w), .i_cmd_addr(cmd_a),
      .i_cmd_wdata(cmd_d), .o_cmd_ready(rdy), .o_rsp_valid(rsp_v), .o_rsp_rdata(rsp_d));
   lrp_port #(.LANES(L)) i_lrp_port (.bus(bus));
   lrp_checker #(.LANES(L)) i_lrp_checker (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .write(bus.write),
      .read(bus.read), .readdata(bus.readdata), .waitrequest(bus.waitrequest));
   // corner offsets 0 and top among spread ones
   function automatic logic [10:0] addr_of(int i);
      return (i == 15) ? 11'h7ff : 11'(i * 32'h45);
   endfunction
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wait_hi(int l, bit rsp);
      int n;
      n = 0;
      while ((rsp ? rsp_v[l] : rdy[l]) !== 1'b1) begin
         @(negedge i_mclk);
         n++;
         if (n > 40) begin
            check("wait bound", 1, 0);
            tally_and_finish();
         end
      end
   endtask
   task automatic xfer(int l, bit wr, int i);
      logic [31:0] d;
      d = $random(seed);
      wait_hi(l, 0);
      cmd_v[l] = 1'b1;
      cmd_w[l] = wr;
      cmd_a[l*11 +: 11] = addr_of(i);
      cmd_d[l*32 +: 32] = d;
      @(posedge i_mclk);
      @(negedge i_mclk);
      cmd_v[l] = 1'b0;
      @(posedge i_mclk);
      @(negedge i_mclk);
      check("strobe", 1, wr ? bus.write[l] : bus.read[l]);
      check("addr", 32'(addr_of(i)), 32'(bus.address[l*11 +: 11]));
      if (wr) begin
         mem[l][i] = d;
         check("wdata", d, bus.writedata[l*32 +: 32]);
      end else begin
         wait_hi(l, 1);
         check("rdata", mem[l][i], rsp_d[l*32 +: 32]);
      end
   endtask
   initial begin
      // reset rises after time zero so the asynchronous reset sees an edge
      #1;
      i_sys_rst = 1'b1;
      repeat (10) @(posedge i_mclk);
      @(negedge i_mclk);
      i_sys_rst = 1'b0;
      // lanes run together to prove slices stay apart
      for (int p = 0; p < 2; p++) begin
         for (int l = 0; l < L; l++) fork
            automatic int k = l;
            for (int i = 0; i < 16; i++) xfer(k, p == 0, i);
         join_none
         wait fork;
         $display("test %0d done", p);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
